// >>> logic/byte_alu_map.svh
// register offsets, field positions, codes and reset values of the byte alu
`ifndef BYTE_ALU_MAP_SVH
`define BYTE_ALU_MAP_SVH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define BA_ADDR_W        10
`define BA_DATA_W        32

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define BA_ACC_OFS       10'h000
`define BA_FLAGS_OFS     10'h004
`define BA_CMD_OFS       10'h008
`define BA_FILE_BASE     10'h200
`define BA_FILE_SEL_BIT  9

// ----------------------------------------
// flags register fields
// ----------------------------------------
`define BA_CARRY_BIT     0
`define BA_NIBBLE_BIT    1
`define BA_ZERO_BIT      2

// ----------------------------------------
// command register fields
// ----------------------------------------
`define BA_CMD_OP_LSB    0
`define BA_CMD_DEST_BIT  3
`define BA_CMD_POS_LSB   4
`define BA_CMD_ADDR_LSB  8
`define BA_CMD_LIT_LSB   16

// ----------------------------------------
// operation codes
// ----------------------------------------
`define BA_OP_NONE       3'h0
`define BA_OP_ADD_IMM    3'h1
`define BA_OP_AND_IMM    3'h2
`define BA_OP_AND_FILE   3'h3
`define BA_OP_ADD_FILE   3'h4
`define BA_OP_CLR_BIT    3'h5
`define BA_OP_SET_BIT    3'h6

// ----------------------------------------
// reset values
// ----------------------------------------
`define BA_ACC_RST       8'h00
`define BA_FLAGS_RST     3'h0
`define BA_CMD_RST       32'h0000_0000
`define BA_ZERO_BYTE     8'h00
`define BA_BIT_ONE       8'h01

`endif

// >>> logic/byte_alu_pkg.sv
// types shared by the byte alu files
`include "byte_alu_map.svh"
package byte_alu_pkg;

  typedef enum logic [2:0] {
    op_none     = `BA_OP_NONE,
    op_add_imm  = `BA_OP_ADD_IMM,
    op_and_imm  = `BA_OP_AND_IMM,
    op_and_file = `BA_OP_AND_FILE,
    op_add_file = `BA_OP_ADD_FILE,
    op_clr_bit  = `BA_OP_CLR_BIT,
    op_set_bit  = `BA_OP_SET_BIT,
    op_spare    = 3'h7
  } alu_op_t;

  typedef enum logic [1:0] {
    bus_idle   = 2'b01,
    bus_answer = 2'b10
  } bus_state_t;

endpackage // byte_alu_pkg

// >>> logic/byte_alu_exec.sv
// combinational execution stage of the byte alu
`timescale 1ns/1ns
`include "byte_alu_map.svh"
module byte_alu_exec
  import byte_alu_pkg::*;
(
  // operation
  input  wire alu_op_t    op,
  input  wire logic       dest_file,
  input  wire logic [2:0] bit_pos,
  input  wire logic [7:0] literal,
  // operands
  input  wire logic [7:0] acc,
  input  wire logic [7:0] file_value,
  // results
  output logic [7:0]      result,
  output logic            carry,
  output logic            nibble_carry,
  output logic            zero,
  output logic            write_acc,
  output logic            write_file,
  output logic            write_arith_flags,
  output logic            write_zero
);

  logic [7:0] operand;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] bit_mask;

  assign operand  = (op == op_add_imm || op == op_and_imm) ? literal : file_value;
  assign sum      = {1'b0, acc} + {1'b0, operand};
  assign low_sum  = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
  assign bit_mask = `BA_BIT_ONE << bit_pos;

  always_comb begin
    result            = acc;
    write_acc         = 1'b0;
    write_file        = 1'b0;
    write_arith_flags = 1'b0;
    write_zero        = 1'b0;
    case (op)
      op_add_imm: begin
        result            = sum[7:0];
        write_acc         = 1'b1;
        write_arith_flags = 1'b1;
        write_zero        = 1'b1;
      end
      op_and_imm: begin
        result     = acc & operand;
        write_acc  = 1'b1;
        write_zero = 1'b1;
      end
      op_and_file: begin
        result     = acc & operand;
        write_acc  = ~dest_file;
        write_file = dest_file;
        write_zero = 1'b1;
      end
      op_add_file: begin
        result            = sum[7:0];
        write_acc         = ~dest_file;
        write_file        = dest_file;
        write_arith_flags = 1'b1;
        write_zero        = 1'b1;
      end
      op_clr_bit: begin
        result     = file_value & ~bit_mask;
        write_file = 1'b1;
      end
      op_set_bit: begin
        result     = file_value | bit_mask;
        write_file = 1'b1;
      end
      default: begin
        result = acc;
      end
    endcase
  end

  assign zero         = (result == `BA_ZERO_BYTE);
  assign carry        = sum[8];
  assign nibble_carry = low_sum[4];

endmodule // byte_alu_exec

// >>> logic/byte_alu_bit_ops.sv
// byte alu with bit operations behind an avalon-mm slave
`timescale 1ns/1ns
`include "byte_alu_map.svh"

// How it works
// - add immediate to acc, update all flags
// - and immediate with acc, zero only
// - and acc with file, zero only
// - add acc and file, update all flags
// - destination bit picks acc or file, for and/add with file only
// - clear one file bit, flags untouched
// - set one file bit, flags untouched
module byte_alu_bit_ops
  import byte_alu_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // avalon-mm slave
  input  wire logic [`BA_ADDR_W-1:0]  address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [3:0]             byteenable,
  input  wire logic [`BA_DATA_W-1:0]  writedata,
  output logic      [`BA_DATA_W-1:0]  readdata,
  output logic                        waitrequest,
  // core state
  output logic      [7:0]             acc_value,
  output logic                        carry_flag,
  output logic                        nibble_carry_flag,
  output logic                        zero_flag
);

  // ----------------------------------------
  // storage and decode
  // ----------------------------------------
  logic [7:0]            file_mem [FILE_DEPTH];
  logic [31:0]           last_cmd;
  bus_state_t            bus_state;
  logic                  take;
  logic                  take_wr;
  logic [6:0]            bus_file_addr;
  logic [6:0]            cmd_file_addr;
  alu_op_t               cmd_op;
  logic [7:0]            exec_result;
  logic                  exec_carry;
  logic                  exec_nibble;
  logic                  exec_zero;
  logic                  exec_wr_acc;
  logic                  exec_wr_file;
  logic                  exec_wr_arith;
  logic                  exec_wr_zero;
  logic                  run_cmd;
  logic [31:0]           next_readdata;
  logic                  sel_acc;
  logic                  sel_flags;
  logic                  sel_cmd;
  logic                  sel_file;
  logic                  acc_sw_wr;
  logic                  flags_sw_wr;
  logic                  file_sw_wr;

  function automatic logic hits(input logic [`BA_ADDR_W-1:0] a, input logic [`BA_ADDR_W-1:0] ofs);
    hits = (a == ofs);
  endfunction

  function automatic logic hits_file(input logic [`BA_ADDR_W-1:0] a);
    hits_file = a[`BA_FILE_SEL_BIT] && (a[1:0] == 2'b00);
  endfunction

  assign take          = (read || write) && (bus_state == bus_idle);
  assign take_wr       = take && write;
  assign bus_file_addr = address[8:2];
  assign cmd_op        = alu_op_t'(writedata[`BA_CMD_OP_LSB +: 3]);
  assign cmd_file_addr = writedata[`BA_CMD_ADDR_LSB +: 7];
  assign run_cmd       = take_wr && sel_cmd && (byteenable != 4'h0);

  // ----------------------------------------
  // address decode and software write strobes
  // ----------------------------------------
  assign sel_acc     = hits(address, `BA_ACC_OFS);
  assign sel_flags   = hits(address, `BA_FLAGS_OFS);
  assign sel_cmd     = hits(address, `BA_CMD_OFS);
  assign sel_file    = hits_file(address);
  // register writes use lane 0 only; commands run on any lane
  assign acc_sw_wr   = take_wr && sel_acc && byteenable[0];
  assign flags_sw_wr = take_wr && sel_flags && byteenable[0];
  assign file_sw_wr  = take_wr && sel_file && byteenable[0];

  // ----------------------------------------
  // execution stage
  // ----------------------------------------
  // command runs on the edge that takes the write, the same edge that drops waitrequest for the answer
  byte_alu_exec byte_alu_exec_inst (
    .op                (cmd_op),
    .dest_file         (writedata[`BA_CMD_DEST_BIT]),
    .bit_pos           (writedata[`BA_CMD_POS_LSB +: 3]),
    .literal           (writedata[`BA_CMD_LIT_LSB +: 8]),
    .acc               (acc_value),
    .file_value        (file_mem[cmd_file_addr]),
    .result            (exec_result),
    .carry             (exec_carry),
    .nibble_carry      (exec_nibble),
    .zero              (exec_zero),
    .write_acc         (exec_wr_acc),
    .write_file        (exec_wr_file),
    .write_arith_flags (exec_wr_arith),
    .write_zero        (exec_wr_zero)
  );

  // ----------------------------------------
  // bus handshake: one wait cycle per access
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_state   <= bus_idle;
      waitrequest <= 1'b1;
    end else begin
      case (bus_state)
        bus_idle: begin
          if (read || write) begin
            bus_state   <= bus_answer;
            waitrequest <= 1'b0;
          end
        end
        bus_answer: begin
          bus_state   <= bus_idle;
          waitrequest <= 1'b1;
        end
        default: begin
          bus_state   <= bus_idle;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (sel_acc) begin
      next_readdata[7:0] = acc_value;
    end else if (sel_flags) begin
      next_readdata[`BA_CARRY_BIT]  = carry_flag;
      next_readdata[`BA_NIBBLE_BIT] = nibble_carry_flag;
      next_readdata[`BA_ZERO_BIT]   = zero_flag;
    end else if (sel_cmd) begin
      next_readdata = last_cmd;
    end else if (sel_file) begin
      next_readdata[7:0] = file_mem[bus_file_addr];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (take && read) begin
      readdata <= next_readdata;
    end
  end

  // ----------------------------------------
  // accumulator
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_value <= `BA_ACC_RST;
    end else if (run_cmd && exec_wr_acc) begin
      acc_value <= exec_result;
    end else if (acc_sw_wr) begin
      acc_value <= writedata[7:0];
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      carry_flag        <= 1'b0;
      nibble_carry_flag <= 1'b0;
      zero_flag         <= 1'b0;
    end else if (run_cmd) begin
      if (exec_wr_arith) begin
        carry_flag        <= exec_carry;
        nibble_carry_flag <= exec_nibble;
      end
      if (exec_wr_zero) begin
        zero_flag <= exec_zero;
      end
    end else if (flags_sw_wr) begin
      carry_flag        <= writedata[`BA_CARRY_BIT];
      nibble_carry_flag <= writedata[`BA_NIBBLE_BIT];
      zero_flag         <= writedata[`BA_ZERO_BIT];
    end
  end

  // ----------------------------------------
  // last command word
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_cmd <= `BA_CMD_RST;
    end else if (run_cmd) begin
      last_cmd <= writedata;
    end
  end

  // ----------------------------------------
  // file registers
  // ----------------------------------------
  // no reset: a file register reads unknown until first written
  always_ff @(posedge clk) begin
    if (run_cmd && exec_wr_file) begin
      file_mem[cmd_file_addr] <= exec_result;
    end else if (file_sw_wr) begin
      file_mem[bus_file_addr] <= writedata[7:0];
    end
  end

endmodule // byte_alu_bit_ops

// >>> dv/byte_alu_monitor.sv
// port-level assertions for the byte alu
`timescale 1ns/1ns
`include "byte_alu_map.svh"
module byte_alu_monitor
  import byte_alu_pkg::*;
#(
  parameter int FILE_DEPTH = 128
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  reset_n,
  // avalon-mm slave
  input wire logic [`BA_ADDR_W-1:0] address,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic [3:0]            byteenable,
  input wire logic [`BA_DATA_W-1:0] writedata,
  input wire logic [`BA_DATA_W-1:0] readdata,
  input wire logic                  waitrequest,
  // core state
  input wire logic [7:0]            acc_value,
  input wire logic                  carry_flag,
  input wire logic                  nibble_carry_flag,
  input wire logic                  zero_flag
);
  logic       cmd_ack;
  logic [2:0] op;
  logic [7:0] lit;
  assign cmd_ack = write && !waitrequest && address == `BA_CMD_OFS && |byteenable;
  assign op      = writedata[2:0];
  assign lit     = writedata[23:16];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  take_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait state");
  answer_once_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer held longer than one cycle");
  add_imm_a: assert property (cmd_ack && op == `BA_OP_ADD_IMM |->
    {carry_flag, acc_value} == {1'b0, $past(acc_value)} + {1'b0, lit} && zero_flag == (acc_value == 8'h00)
    && nibble_carry_flag == ({1'b0, $past(acc_value[3:0])} + {1'b0, lit[3:0]} > 5'd15))
    else $error("add immediate result or flags wrong");
  and_imm_a: assert property (cmd_ack && op == `BA_OP_AND_IMM |->
    acc_value == ($past(acc_value) & lit) && zero_flag == (acc_value == 8'h00) && $stable(carry_flag))
    else $error("and immediate result or flags wrong");
  and_file_a: assert property (cmd_ack && op == `BA_OP_AND_FILE && !writedata[3] |->
    (acc_value & ~$past(acc_value)) == 8'h00 && zero_flag == (acc_value == 8'h00) && $stable(nibble_carry_flag))
    else $error("and with file result or flags wrong");
  add_file_a: assert property (cmd_ack && op == `BA_OP_ADD_FILE && !writedata[3] |->
    carry_flag == (acc_value < $past(acc_value)) && zero_flag == (acc_value == 8'h00)
    && nibble_carry_flag == (acc_value[3:0] < $past(acc_value[3:0])))
    else $error("add with file flags wrong");
  file_dest_a: assert property (cmd_ack && op inside {`BA_OP_AND_FILE, `BA_OP_ADD_FILE} && writedata[3]
    |-> $stable(acc_value)) else $error("file destination disturbed acc");
  bit_ops_a: assert property (cmd_ack && op inside {`BA_OP_CLR_BIT, `BA_OP_SET_BIT} |->
    $stable({acc_value, carry_flag, nibble_carry_flag, zero_flag})) else $error("bit op changed acc or flags");
  read_data_a: assert property ($changed(readdata) |-> read && !waitrequest)
    else $error("read data moved outside a read answer");
endmodule // byte_alu_monitor

bind byte_alu_bit_ops byte_alu_monitor #(.FILE_DEPTH(FILE_DEPTH)) byte_alu_monitor_inst (.clk, .reset_n,
  .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .acc_value, .carry_flag,
  .nibble_carry_flag, .zero_flag);

// >>> dv/testbench.sv
// self-checking bench for the byte alu
`timescale 1ns/1ns
`include "byte_alu_map.svh"
module testbench;
  import byte_alu_pkg::*;
  logic                  clk = 0;
  logic                  reset_n = 0;
  logic [`BA_ADDR_W-1:0] address = '0;
  logic                  read = 0;
  logic                  write = 0;
  logic [3:0]            byteenable = 4'hF;
  logic [`BA_DATA_W-1:0] writedata = '0;
  logic [`BA_DATA_W-1:0] readdata;
  logic                  waitrequest;
  logic [7:0]            acc_value;
  logic                  carry_flag;
  logic                  nibble_carry_flag;
  logic                  zero_flag;
  logic [31:0]           rd;
  int                    fails = 0;
  int                    check_count = 0;
  always #4 clk = ~clk;
  byte_alu_bit_ops #(.FILE_DEPTH(128)) byte_alu_bit_ops_inst (.clk, .reset_n, .address, .read, .write,
    .byteenable, .writedata, .readdata, .waitrequest, .acc_value, .carry_flag, .nibble_carry_flag, .zero_flag);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic op_run(input logic [2:0] op, input logic dest, input logic [6:0] n, input logic [2:0] b,
                        input logic [7:0] a, input logic [7:0] f, input logic [7:0] lit, input logic [2:0] fl);
    logic [8:0] sum;
    logic [7:0] src, r, ea, ef;
    logic [2:0] efl;
    logic [9:0] fa;
    src = (op <= 3'h2) ? lit : f;
    sum = {1'b0, a} + {1'b0, src};
    fa = 10'h200 + {1'b0, n, 2'b00};
    case (op)
      3'h1, 3'h4: r = sum[7:0];
      3'h2, 3'h3: r = a & src;
      3'h5: r = f & ~(8'h01 << b);
      default: r = f | (8'h01 << b);
    endcase
    efl = fl;
    if (op == 3'h1 || op == 3'h4) efl[1:0] = {({1'b0, a[3:0]} + {1'b0, src[3:0]}) > 5'd15, sum[8]};
    if (op <= 3'h4) efl[2] = (r == 8'h00);
    ea = a;
    ef = f;
    if (op <= 3'h2 || (op <= 3'h4 && !dest)) ea = r;
    else ef = r;
    bus(1'b1, fa, {24'h0, f});
    bus(1'b1, `BA_ACC_OFS, {24'h0, a});
    bus(1'b1, `BA_FLAGS_OFS, {29'h0, fl});
    bus(1'b1, `BA_CMD_OFS, {8'h00, lit, 1'b0, n, 1'b0, b, dest, op});
    bus(1'b0, `BA_ACC_OFS, '0);
    check(rd, {24'h0, ea}, "acc register");
    check({24'h0, acc_value}, {24'h0, ea}, "acc pins");
    bus(1'b0, `BA_FLAGS_OFS, '0);
    check(rd, {29'h0, efl}, "flags register");
    check({29'h0, zero_flag, nibble_carry_flag, carry_flag}, {29'h0, efl}, "flag pins");
    bus(1'b0, fa, '0);
    check(rd, {24'h0, ef}, "file register");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_literal;
    op_run(3'h1, 0, 7'h00, 0, 8'hFF, 8'h00, 8'h01, 3'h0);
    op_run(3'h1, 1, 7'h01, 0, 8'h08, 8'h00, 8'h08, 3'h4);
    op_run(3'h1, 0, 7'h02, 0, 8'h00, 8'h00, 8'h00, 3'h3);
    op_run(3'h2, 0, 7'h03, 0, 8'hF0, 8'h00, 8'h0F, 3'h3);
    op_run(3'h2, 1, 7'h04, 0, 8'hFF, 8'h11, 8'hA5, 3'h4);
  endtask
  task automatic t_file_arith;
    op_run(3'h3, 0, 7'h7F, 0, 8'hC4, 8'h3C, 8'hFF, 3'h3);
    op_run(3'h3, 1, 7'h7F, 0, 8'hC3, 8'h3C, 8'h00, 3'h0);
    op_run(3'h4, 0, 7'h00, 0, 8'h9A, 8'h66, 8'h00, 3'h0);
    op_run(3'h4, 1, 7'h40, 0, 8'h0F, 8'h01, 8'h00, 3'h5);
  endtask
  task automatic t_bit_ops;
    for (int b = 0; b < 8; b++) begin
      op_run(3'h5, 1, 7'(b * 9), 3'(b), 8'h5A, 8'hFF, 8'h00, 3'h7);
      op_run(3'h6, 0, 7'(b * 9), 3'(b), 8'h00, 8'h00, 8'h00, 3'h2);
    end
  endtask
  task automatic t_bus_misc;
    bus(1'b1, `BA_ACC_OFS, 32'h0000_005A);
    bus(1'b1, 10'h00C, 32'h0000_0011);
    bus(1'b0, 10'h00C, '0);
    check(rd, 32'h0000_0000, "unmapped read");
    byteenable <= 4'h0;
    bus(1'b1, `BA_ACC_OFS, 32'h0000_00A5);
    byteenable <= 4'hF;
    bus(1'b1, `BA_CMD_OFS, 32'h00AB_0007);
    byteenable <= 4'h0;
    bus(1'b1, `BA_CMD_OFS, 32'h0011_0001);
    byteenable <= 4'hF;
    bus(1'b0, `BA_CMD_OFS, '0);
    check(rd, 32'h00AB_0007, "command word readback");
    bus(1'b0, `BA_FLAGS_OFS, '0);
    check(rd, 32'h0000_0002, "flags after skipped commands");
    bus(1'b0, `BA_ACC_OFS, '0);
    check(rd, 32'h0000_005A, "acc after ignored writes");
  endtask
  task automatic t_reset;
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check(readdata, 32'h0000_0000, "readdata after reset");
    check({20'h0, waitrequest, acc_value, zero_flag, nibble_carry_flag, carry_flag}, 32'h0000_0800, "state after reset");
    bus(1'b1, `BA_ACC_OFS, 32'h0000_0033);
    bus(1'b0, `BA_ACC_OFS, '0);
    check(rd, 32'h0000_0033, "acc after second reset");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check({21'h0, acc_value, zero_flag, nibble_carry_flag, carry_flag}, 32'h0000_0000, "reset state");
    t_literal;
    t_file_arith;
    t_bit_ops;
    t_bus_misc;
    t_reset;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict;
  end
endmodule // testbench
